// >>> hdl/fra_regs.vh
// Register offsets, field positions, reset values and timing counts of the fast result accumulator
`ifndef FRA_REGS_VH
`define FRA_REGS_VH
// ==================================================
// Register byte offsets
`define FRA_CTRL_ADDR 8'h00
`define FRA_STAT_ADDR 8'h04
`define FRA_LATEST_ADDR 8'h08
`define FRA_Q_ADDR 8'h0C
`define FRA_CUR1_ADDR 8'h10
`define FRA_CUR2_ADDR 8'h14
`define FRA_PWR1_ADDR 8'h18
`define FRA_PWR2_ADDR 8'h1C
`define FRA_CHG1_ADDR 8'h20
`define FRA_CHG2_ADDR 8'h24
`define FRA_CHG3_ADDR 8'h28
`define FRA_NRG1_ADDR 8'h2C
`define FRA_NRG2_ADDR 8'h30
`define FRA_NRG4_ADDR 8'h34
`define FRA_TIME1_ADDR 8'h38
`define FRA_TIME2_ADDR 8'h3C
`define FRA_TIME3_ADDR 8'h40
`define FRA_TIME4_ADDR 8'h44
`define FRA_ACCCFG_ADDR 8'h48
`define FRA_CMD_ADDR 8'h4C
// ==================================================
// Control register fields
`define FRA_CTRL_REPEAT 0
`define FRA_CTRL_FREP 1
`define FRA_CTRL_CH1F 2
`define FRA_CTRL_CH2F 3
`define FRA_CTRL_SIDEF 4
`define FRA_CTRL_PV1 5
`define FRA_CTRL_PV2 6
`define FRA_CTRL_RESET 7'h00
// Command register: bit 0 fast trigger, bits 3:2 queue select for reads
`define FRA_CMD_TRIG 0
// Accumulator config: [1:0] sign mode, [15:8] minimum current magnitude
`define FRA_ACCCFG_RESET 16'h0000
// ==================================================
// Qualifier and freshness codes
`define FRA_TAG_OK 8'h00
`define FRA_TAG_READ 8'h55
`define FRA_TAG_OVER 8'hAA
`define FRA_FRESH_NEW 4'hF
`define FRA_FRESH_OLD 4'h0
// ==================================================
// Timing at 25 MHz
`define FRA_CLK_HZ 25000000
`define FRA_SLOW_MS 100
`define FRA_FAST_US 782
`define FRA_SIDE_RESUME_MS 300
`define FRA_SLOW_CYC ((`FRA_CLK_HZ / 1000) * `FRA_SLOW_MS)
`define FRA_FAST_CYC ((`FRA_CLK_HZ / 1000000) * `FRA_FAST_US)
`define FRA_RESUME_CYC ((`FRA_CLK_HZ / 1000) * `FRA_SIDE_RESUME_MS)
`define FRA_AVG_N 128
`define FRA_AVG_SH 7
`endif

// >>> hdl/fra_top.v
// Fast result accumulator: fast result readback, sample queues, averaging and accumulation
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fra_regs.vh"
module fra_top #(
  parameter DEPTH = 1000,
  parameter AW = 10,
  parameter SLOW_CYC = `FRA_SLOW_CYC,
  parameter RESUME_CYC = `FRA_RESUME_CYC
) (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [14:0] cur1_result,
  input wire [14:0] cur2_result,
  input wire [14:0] pwr1_result,
  input wire [14:0] pwr2_result,
  input wire [14:0] side_result,
  output reg [2:0] side_slot,
  output reg side_round_robin
);
  localparam FAST_CYC = `FRA_FAST_CYC;
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SINGLE = 3'b010;
  localparam [2:0] ST_REPEAT = 3'b100;
  // ==================================================
  // Registers
  reg [6:0] ctrl;
  reg [15:0] acccfg;
  reg [1:0] qsel;
  reg [2:0] fstate;
  reg [14:0] l_cur1, l_cur2, l_pack, l_side;
  reg fresh;
  reg [15:0] cur1_avg, cur2_avg, pwr1_avg, pwr2_avg;
  reg [31:0] chg1, chg2, chg3, nrg1, nrg2, nrg4, t1, t2, t3, t4;
  reg [21:0] sum_c1, sum_c2, sum_p1, sum_p2;
  reg [6:0] avg_cnt;
  reg [23:0] slow_cnt;
  reg [15:0] fast_cnt;
  reg [27:0] resume_cnt;
  reg [2:0] lat_byte;
  reg [1:0] q_byte;
  reg [14:0] q_mem [0:4*DEPTH-1];
  reg [7:0] q_tag [0:4*DEPTH-1];
  reg [AW-1:0] q_wr;
  reg [AW-1:0] q_rd [0:3];
  reg [14:0] q_data;
  reg [7:0] q_tagv;
  wire repeat_on = ctrl[`FRA_CTRL_REPEAT];
  wire dual_fast = ctrl[`FRA_CTRL_CH1F] & ctrl[`FRA_CTRL_CH2F];
  wire any_fast = ctrl[`FRA_CTRL_CH1F] | ctrl[`FRA_CTRL_CH2F] | ctrl[`FRA_CTRL_SIDEF];
  // ==================================================
  // Bus handshake
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  reg [7:0] wa;
  reg [31:0] wd;
  reg [3:0] ws;
  reg have_a, have_d;
  wire do_wr = have_a & have_d & ~s_axi_bvalid;
  wire wr_ctrl = do_wr & (wa == `FRA_CTRL_ADDR) & ws[0];
  wire wr_trig = do_wr & (wa == `FRA_CMD_ADDR) & ws[0] & wd[`FRA_CMD_TRIG];
  wire [6:0] new_ctrl = wd[6:0];
  // Starts of fast conversion, taken only with the repeat bit set: trigger with fast repeat off, or fast repeat bit rising
  wire start_single = wr_trig & ~ctrl[`FRA_CTRL_FREP] & any_fast;
  wire start_rep = wr_ctrl & new_ctrl[`FRA_CTRL_FREP] & ~ctrl[`FRA_CTRL_FREP];
  wire retag = start_single | start_rep;
  wire flush = wr_ctrl & ctrl[`FRA_CTRL_REPEAT] & ~new_ctrl[`FRA_CTRL_REPEAT];
  wire sample = (fstate != ST_IDLE) & (fast_cnt == FAST_CYC - 1);
  // Sign and threshold gate for accumulation
  function acc_ok;
    input [15:0] v;
    input [15:0] cfg;
    begin
      acc_ok = ((cfg[1:0] == 2'd0) || (cfg[1:0] == 2'd1 && !v[15]) ||
        (cfg[1:0] == 2'd2 && v[15])) && ((v[15] ? -v : v) >= {cfg[15:8], 7'h00});
    end
  endfunction
  // ==================================================
  // Fast sequencer
  always @(posedge mclk) begin
    if (!rst_n) begin
      fstate <= ST_IDLE;
      fast_cnt <= 16'h0000;
    end else begin
      case (fstate)
        ST_IDLE: begin
          fast_cnt <= 16'h0000;
          if (start_single && repeat_on)
            fstate <= ST_SINGLE;
          else if (start_rep && new_ctrl[`FRA_CTRL_REPEAT])
            fstate <= ST_REPEAT;
        end
        ST_SINGLE: begin
          fast_cnt <= sample ? 16'h0000 : fast_cnt + 16'h0001;
          if (sample || flush)
            fstate <= ST_IDLE;
        end
        ST_REPEAT: begin
          fast_cnt <= sample ? 16'h0000 : fast_cnt + 16'h0001;
          if (!ctrl[`FRA_CTRL_FREP] || !repeat_on)
            fstate <= ST_IDLE;
        end
        default: fstate <= ST_IDLE;
      endcase
    end
  end
  // ==================================================
  // Side channel mode and slow timebase
  always @(posedge mclk) begin
    if (!rst_n) begin
      side_round_robin <= 1'b1;
      resume_cnt <= 28'h0000000;
      slow_cnt <= 24'h000000;
      side_slot <= 3'h0;
    end else begin
      if (ctrl[`FRA_CTRL_SIDEF] && ctrl[`FRA_CTRL_FREP]) begin
        side_round_robin <= 1'b0;
        resume_cnt <= 28'h0000000;
      end else if (!side_round_robin) begin
        resume_cnt <= resume_cnt + 28'h0000001;
        if (resume_cnt == RESUME_CYC - 1)
          side_round_robin <= 1'b1;
      end
      if (repeat_on) begin
        slow_cnt <= (slow_cnt == SLOW_CYC - 1) ? 24'h000000 : slow_cnt + 24'h000001;
      end
      // Slots 0..5: pack, temp, supply, slot1, slot2, reference
      if (!side_round_robin)
        side_slot <= 3'h0;
      else if (slow_cnt == 24'h000000 && repeat_on)
        side_slot <= 3'h0;
      else if (slow_cnt == (SLOW_CYC / 6) * (side_slot + 1) && side_slot != 3'h5)
        side_slot <= side_slot + 3'h1;
    end
  end
  // ==================================================
  // Latest results
  always @(posedge mclk) begin
    if (!rst_n) begin
      l_cur1 <= 15'h0000;
      l_cur2 <= 15'h0000;
      l_pack <= 15'h0000;
      l_side <= 15'h0000;
      fresh <= 1'b0;
    end else begin
      if (sample) begin
        l_cur1 <= ctrl[`FRA_CTRL_CH1F] ? cur1_result : 15'h0000;
        l_cur2 <= ctrl[`FRA_CTRL_CH2F] ? cur2_result : 15'h0000;
        if (ctrl[`FRA_CTRL_CH1F] && ctrl[`FRA_CTRL_PV1])
          l_pack <= pwr1_result;
        else if (ctrl[`FRA_CTRL_CH2F] && ctrl[`FRA_CTRL_PV2])
          l_pack <= pwr2_result;
        else
          l_pack <= 15'h0000;
        l_side <= side_round_robin ? 15'h0000 : side_result;
        fresh <= 1'b1;
      end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `FRA_LATEST_ADDR &&
        lat_byte == 3'h4)
        fresh <= 1'b0;
    end
  end
  // ==================================================
  // Sample queues: one shared write pointer, per-queue read pointers
  // A sample is consumed when its qualifier byte is requested
  wire q_pop = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `FRA_Q_ADDR) &&
    q_byte == 2'd2;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gq
      wire rd_pop = q_pop && qsel == g;
      always @(posedge mclk) begin
        if (!rst_n || flush)
          q_rd[g] <= {AW{1'b0}};
        else if (sample && q_wr == q_rd[g] && q_tag[g*DEPTH+q_rd[g]] == `FRA_TAG_OK)
          q_rd[g] <= (q_rd[g] == DEPTH - 1) ? {AW{1'b0}} : q_rd[g] + 1'b1;
        else if (rd_pop)
          q_rd[g] <= (q_rd[g] == DEPTH - 1) ? {AW{1'b0}} : q_rd[g] + 1'b1;
      end
    end
  endgenerate
  integer k;
  always @(posedge mclk) begin
    if (!rst_n || flush) begin
      q_wr <= {AW{1'b0}};
      for (k = 0; k < 4 * DEPTH; k = k + 1)
        q_tag[k] <= `FRA_TAG_READ;
    end else if (retag) begin
      for (k = 0; k < 4 * DEPTH; k = k + 1)
        q_tag[k] <= `FRA_TAG_READ;
    end else begin
      // A new sample landing on the same slot wins over the read mark
      if (q_pop)
        q_tag[qsel*DEPTH+q_rd[qsel]] <= `FRA_TAG_READ;
      if (sample && fstate == ST_REPEAT) begin
        for (k = 0; k < 4; k = k + 1) begin
          // An unread slot being replaced flags the next-oldest as overwritten
          if (q_tag[k*DEPTH+q_wr] == `FRA_TAG_OK)
            q_tag[k*DEPTH+((q_wr == DEPTH - 1) ? 0 : q_wr + 1)] <= `FRA_TAG_OVER;
          q_tag[k*DEPTH+q_wr] <= `FRA_TAG_OK;
        end
        q_mem[0*DEPTH+q_wr] <= cur1_result;
        q_mem[1*DEPTH+q_wr] <= cur2_result;
        q_mem[2*DEPTH+q_wr] <= ctrl[`FRA_CTRL_PV1] ? pwr1_result : pwr2_result;
        q_mem[3*DEPTH+q_wr] <= side_result;
        q_wr <= (q_wr == DEPTH - 1) ? {AW{1'b0}} : q_wr + 1'b1;
      end
    end
  end
  always @* begin
    q_data = q_mem[qsel*DEPTH+q_rd[qsel]];
    q_tagv = q_tag[qsel*DEPTH+q_rd[qsel]];
  end
  // ==================================================
  // Averaging and accumulation
  // Totals including the current sample; the 128th one closes the group
  wire [21:0] c1_tot = sum_c1 + {{7{cur1_result[14]}}, cur1_result};
  wire [21:0] c2_tot = sum_c2 + {{7{cur2_result[14]}}, cur2_result};
  wire [21:0] p1_tot = sum_p1 + {11'h000, pwr1_result[14:4]};
  wire [21:0] p2_tot = sum_p2 + {11'h000, pwr2_result[14:4]};
  always @(posedge mclk) begin
    if (!rst_n) begin
      avg_cnt <= 7'h00;
      {sum_c1, sum_c2, sum_p1, sum_p2} <= 88'h0;
      {cur1_avg, cur2_avg, pwr1_avg, pwr2_avg} <= 64'h0;
      {chg1, chg2, chg3, nrg1, nrg2, nrg4} <= 192'h0;
      {t1, t2, t3, t4} <= 128'h0;
    end else if (sample && dual_fast) begin
      avg_cnt <= avg_cnt + 7'h01;
      if (avg_cnt == `FRA_AVG_N - 1) begin
        cur1_avg <= {c1_tot[21], c1_tot[21:7]};
        cur2_avg <= {c2_tot[21], c2_tot[21:7]};
        pwr1_avg <= {1'b0, p1_tot[21:7]};
        pwr2_avg <= {1'b0, p2_tot[21:7]};
        {sum_c1, sum_c2, sum_p1, sum_p2} <= 88'h0;
      end else begin
        sum_c1 <= sum_c1 + {{7{cur1_result[14]}}, cur1_result};
        sum_c2 <= sum_c2 + {{7{cur2_result[14]}}, cur2_result};
        sum_p1 <= sum_p1 + {11'h000, pwr1_result[14:4]};
        sum_p2 <= sum_p2 + {11'h000, pwr2_result[14:4]};
      end
      // Per-sample integration over the accumulator sets
      if (acc_ok({cur1_result[14], cur1_result}, acccfg)) begin
        chg1 <= chg1 + {{17{cur1_result[14]}}, cur1_result};
        t1 <= t1 + 32'h1;
        if (!ctrl[`FRA_CTRL_PV1])
          nrg1 <= nrg1 + {21'h0, pwr1_result[14:4]};
      end
      if (acc_ok({cur2_result[14], cur2_result}, acccfg)) begin
        chg2 <= chg2 + {{17{cur2_result[14]}}, cur2_result};
        t2 <= t2 + 32'h1;
        if (!ctrl[`FRA_CTRL_PV2])
          nrg2 <= nrg2 + {21'h0, pwr2_result[14:4]};
      end
      chg3 <= chg3 + {{17{cur1_result[14]}}, cur1_result} + {{17{cur2_result[14]}}, cur2_result};
      t3 <= t3 + 32'h1;
      nrg4 <= nrg4 + (ctrl[`FRA_CTRL_PV1] ? 32'h0 : {21'h0, pwr1_result[14:4]}) +
        (ctrl[`FRA_CTRL_PV2] ? 32'h0 : {21'h0, pwr2_result[14:4]});
      t4 <= t4 + 32'h1;
    end
  end
  // ==================================================
  // AXI4-Lite write channel
  always @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      have_a <= 1'b0;
      have_d <= 1'b0;
      wa <= 8'h00;
      wd <= 32'h0;
      ws <= 4'h0;
      ctrl <= `FRA_CTRL_RESET;
      acccfg <= `FRA_ACCCFG_RESET;
      qsel <= 2'b00;
    end else begin
      if (aw_hs) begin
        wa <= s_axi_awaddr;
        have_a <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        wd <= s_axi_wdata;
        ws <= s_axi_wstrb;
        have_d <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        have_a <= 1'b0;
        have_d <= 1'b0;
        s_axi_bresp <= 2'b00;
        if (wa == `FRA_CTRL_ADDR) begin
          if (ws[0])
            ctrl <= new_ctrl;
        end else if (wa == `FRA_ACCCFG_ADDR) begin
          if (ws[0])
            acccfg[7:0] <= wd[7:0];
          if (ws[1])
            acccfg[15:8] <= wd[15:8];
        end else if (wa == `FRA_CMD_ADDR) begin
          if (ws[0])
            qsel <= wd[3:2];
        end else
          s_axi_bresp <= 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // ==================================================
  // AXI4-Lite read channel; latest port streams a 15-bit value and queue port a byte per read
  wire [59:0] lat_word = {l_side, l_pack, l_cur2, l_cur1};
  always @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
      lat_byte <= 3'h0;
      q_byte <= 2'd0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr == `FRA_CTRL_ADDR)
        s_axi_rdata <= {25'h0, ctrl};
      else if (s_axi_araddr == `FRA_STAT_ADDR)
        s_axi_rdata <= {26'h0, side_slot, side_round_robin, fstate != ST_IDLE, fresh};
      else if (s_axi_araddr == `FRA_LATEST_ADDR) begin
        // One 15-bit value per read, low byte in the lowest lane; fifth item is freshness
        if (lat_byte == 3'h4)
          s_axi_rdata <= {28'h0, fresh ? `FRA_FRESH_NEW : `FRA_FRESH_OLD};
        else
          s_axi_rdata <= {17'h0, lat_word[lat_byte*15 +: 15]};
      end else if (s_axi_araddr == `FRA_Q_ADDR) begin
        if (q_byte == 2'd0)
          s_axi_rdata <= {25'h0, q_data[14:8]};
        else if (q_byte == 2'd1)
          s_axi_rdata <= {24'h0, q_data[7:0]};
        else
          s_axi_rdata <= {24'h0, q_tagv};
      end else if (s_axi_araddr == `FRA_CUR1_ADDR)
        s_axi_rdata <= {{16{cur1_avg[15]}}, cur1_avg};
      else if (s_axi_araddr == `FRA_CUR2_ADDR)
        s_axi_rdata <= {{16{cur2_avg[15]}}, cur2_avg};
      else if (s_axi_araddr == `FRA_PWR1_ADDR)
        s_axi_rdata <= {16'h0, pwr1_avg};
      else if (s_axi_araddr == `FRA_PWR2_ADDR)
        s_axi_rdata <= {16'h0, pwr2_avg};
      else if (s_axi_araddr == `FRA_CHG1_ADDR)
        s_axi_rdata <= chg1;
      else if (s_axi_araddr == `FRA_CHG2_ADDR)
        s_axi_rdata <= chg2;
      else if (s_axi_araddr == `FRA_CHG3_ADDR)
        s_axi_rdata <= chg3;
      else if (s_axi_araddr == `FRA_NRG1_ADDR)
        s_axi_rdata <= nrg1;
      else if (s_axi_araddr == `FRA_NRG2_ADDR)
        s_axi_rdata <= nrg2;
      else if (s_axi_araddr == `FRA_NRG4_ADDR)
        s_axi_rdata <= nrg4;
      else if (s_axi_araddr == `FRA_TIME1_ADDR)
        s_axi_rdata <= t1;
      else if (s_axi_araddr == `FRA_TIME2_ADDR)
        s_axi_rdata <= t2;
      else if (s_axi_araddr == `FRA_TIME3_ADDR)
        s_axi_rdata <= t3;
      else if (s_axi_araddr == `FRA_TIME4_ADDR)
        s_axi_rdata <= t4;
      else if (s_axi_araddr == `FRA_ACCCFG_ADDR)
        s_axi_rdata <= {16'h0, acccfg};
      else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'b10;
      end
      if (s_axi_araddr == `FRA_LATEST_ADDR)
        lat_byte <= (lat_byte == 3'h4) ? 3'h0 : lat_byte + 3'h1;
      if (s_axi_araddr == `FRA_Q_ADDR)
        q_byte <= (q_byte == 2'd2) ? 2'd0 : q_byte + 2'd1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/fra_conv_model.sv
// Converter front end model feeding fixed fast results
`timescale 1ns/1ps
`default_nettype none
module fra_conv_model (
  output wire logic [14:0] cur1,
  output wire logic [14:0] cur2,
  output wire logic [14:0] pwr1,
  output wire logic [14:0] pwr2,
  output wire logic [14:0] side
);
  // ==================================================
  // Fixed 15-bit results, distinct per converter so a swap shows
  assign cur1 = 15'h1234;
  assign cur2 = 15'h2345;
  assign pwr1 = 15'h3456;
  assign pwr2 = 15'h4567;
  assign side = 15'h0567;
endmodule
`default_nettype wire

// >>> verif/fra_props_properties.sv
// Port checker for the fast result accumulator
`timescale 1ns/1ps
`default_nettype none
module fra_props #(parameter RESUME_CYC = 300) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] side_slot,
  input wire logic side_round_robin
);
  // ==================================================
  // Cycles spent out of round-robin
  int low_cnt;
  always @(posedge mclk) begin
    if (!rst_n || side_round_robin) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==================================================
  // Assertions
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  chk_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h4C |=> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  chk_rr_resume: assert property ($rose(side_round_robin) |-> low_cnt >= RESUME_CYC - 1)
    else $error("round-robin resumed early");
  chk_slot_range: assert property (side_slot <= 3'h5)
    else $error("round-robin slot out of range");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  cov_resume: cover property ($rose(side_round_robin));
endmodule
bind fra_top fra_props #(.RESUME_CYC(RESUME_CYC)) fra_props_inst (.mclk, .rst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .side_slot, .side_round_robin);
`default_nettype wire

// >>> verif/tb_fast_result_accumulator.sv
// Register-level testbench of the fast result accumulator
`timescale 1ns/1ps
`default_nettype none
`include "fra_regs.vh"
module tb_fast_result_accumulator;
  logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, side_rr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [14:0] c1, c2, p1, p2, sd;
  logic [2:0] slot;
  int miscompares, cmp_count, i;
  fra_conv_model fra_conv_model_inst (.cur1(c1), .cur2(c2), .pwr1(p1), .pwr2(p2), .side(sd));
  fra_top #(.DEPTH(8), .AW(3), .SLOW_CYC(600), .RESUME_CYC(300)) fra_top_inst (
    .mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cur1_result(c1), .cur2_result(c2), .pwr1_result(p1), .pwr2_result(p2),
    .side_result(sd), .side_slot(slot), .side_round_robin(side_rr));
  initial begin
    mclk = 0;
    forever #20 mclk = ~mclk;
  end
  // ==================================================
  // Bus tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) break;
    end
    rs = bresp;
    bready <= 0;
    if (n == 50) miscompares++;
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 0;
    if (n == 50) miscompares++;
  endtask
  task wait_fresh;
    for (i = 0; i < 12000; i++) begin
      axi_rd(`FRA_STAT_ADDR, d, r);
      if (d[0] === 1'b1) break;
    end
    check(d[0], 1'b1);
  endtask
  task end_sim;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    miscompares++;
    end_sim;
  end
  // ==================================================
  // Tests
  initial begin
    miscompares = 0;
    cmp_count = 0;
    rst_n = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    axi_rd(`FRA_CTRL_ADDR, d, r);
    check(d, 32'h0);
    axi_rd(`FRA_STAT_ADDR, d, r);
    check(d & 32'h4, 32'h4);
    $display("test reset done");
    axi_rd(8'h80, d, r);
    check(r, 2'b10);
    axi_wr(8'h80, 32'h1, r);
    check(r, 2'b10);
    $display("test unmapped done");
    axi_wr(`FRA_CTRL_ADDR, 32'h0D, r);
    axi_rd(`FRA_CTRL_ADDR, d, r);
    check(d, 32'h0D);
    axi_wr(`FRA_CMD_ADDR, 32'h1, r);
    wait_fresh;
    for (i = 0; i < 10; i++) begin
      axi_rd(`FRA_LATEST_ADDR, d, r);
      if (i == 0) check(d, {17'h0, c1});
      if (i == 1) check(d, {17'h0, c2});
      if (i == 2) check(d, 32'h0);
      if (i == 4) check(d, 32'hF);
      if (i == 9) check(d, 32'h0);
    end
    $display("test latest done");
    axi_wr(`FRA_CTRL_ADDR, 32'h6D, r);
    axi_wr(`FRA_CMD_ADDR, 32'h1, r);
    wait_fresh;
    for (i = 0; i < 5; i++) begin
      axi_rd(`FRA_LATEST_ADDR, d, r);
      if (i == 2) check(d, {17'h0, p1});
    end
    $display("test pack source done");
    axi_wr(`FRA_CTRL_ADDR, 32'h13, r);
    repeat (3) @(posedge mclk);
    check(side_rr, 1'b0);
    check(slot, 3'h0);
    repeat (50) @(posedge mclk);
    axi_wr(`FRA_CTRL_ADDR, 32'h01, r);
    repeat (280) @(posedge mclk);
    check(side_rr, 1'b0);
    repeat (60) @(posedge mclk);
    check(side_rr, 1'b1);
    $display("test side channel done");
    // Repeated fast run: one sample lands in queue slot 0
    axi_wr(`FRA_CTRL_ADDR, 32'h0F, r);
    wait_fresh;
    axi_rd(`FRA_Q_ADDR, d, r);
    check(d, {25'h0, c1[14:8]});
    axi_rd(`FRA_Q_ADDR, d, r);
    check(d, {24'h0, c1[7:0]});
    axi_rd(`FRA_Q_ADDR, d, r);
    check(d, {24'h0, `FRA_TAG_OK});
    for (i = 0; i < 3; i++) axi_rd(`FRA_Q_ADDR, d, r);
    check(d, {24'h0, `FRA_TAG_READ});
    // Leaving repeat-measure rewinds the queue to slot 0
    axi_wr(`FRA_CTRL_ADDR, 32'h00, r);
    for (i = 0; i < 3; i++) begin
      axi_rd(`FRA_Q_ADDR, d, r);
      if (i == 0) check(d, {25'h0, c1[14:8]});
      if (i == 2) check(d, {24'h0, `FRA_TAG_READ});
    end
    $display("test queue done");
    // Three dual fast samples so far, power mode on channel one in one of them
    axi_rd(`FRA_CHG1_ADDR, d, r);
    check(d, 32'h0000369C);
    axi_rd(`FRA_CHG3_ADDR, d, r);
    check(d, 32'h0000A06B);
    axi_rd(`FRA_NRG1_ADDR, d, r);
    check(d, 32'h0000068A);
    axi_rd(`FRA_TIME4_ADDR, d, r);
    check(d, 32'h00000003);
    $display("test accumulation done");
    end_sim;
  end
endmodule
`default_nettype wire
